// ---- hdl/sbst_pkg.sv ----
// Shared constants and types of the SRAM boundary-scan test access port
package sbst_pkg;

  // Register lengths
  localparam int IR_W       = 3;
  localparam int ID_W       = 32;
  localparam int NCELL_X18  = 51;
  localparam int NCELL_X36  = 70;

  // Consecutive test-clock rises with mode select high that force reset
  localparam int TMS_RESET_EDGES = 5;

  // Instruction codes
  localparam logic [IR_W-1:0] INS_ZERO   = 3'h0;
  localparam logic [IR_W-1:0] INS_IDENT  = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPZ  = 3'h2;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h3;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;

  // Fixed values loaded on capture
  localparam logic [IR_W-1:0] IR_CAPTURE  = 3'h1;
  localparam logic            BYP_CAPTURE = 1'h0;
  localparam logic            ID_FIX_BIT  = 1'h1;

  // Boundary cell numbers (cell 1 is nearest the serial output)
  localparam int CELL_MODE2     = 1;
  localparam int CELL_SLEEP_X18 = 6;
  localparam int CELL_CLK_X18   = 13;

  // Controller states, standard encodings
  typedef enum logic [3:0] {
    ST_EX2_DR   = 4'h0,
    ST_EX1_DR   = 4'h1,
    ST_SHIFT_DR = 4'h2,
    ST_PAUSE_DR = 4'h3,
    ST_SEL_IR   = 4'h4,
    ST_UPD_DR   = 4'h5,
    ST_CAP_DR   = 4'h6,
    ST_SEL_DR   = 4'h7,
    ST_EX2_IR   = 4'h8,
    ST_EX1_IR   = 4'h9,
    ST_SHIFT_IR = 4'hA,
    ST_PAUSE_IR = 4'hB,
    ST_IDLE     = 4'hC,
    ST_UPD_IR   = 4'hD,
    ST_CAP_IR   = 4'hE,
    ST_RESET    = 4'hF
  } sbst_state_e;

  // Data register selected by the instruction
  typedef enum logic [1:0] {
    DR_BYPASS = 2'h0,
    DR_IDENT  = 2'h1,
    DR_BOUND  = 2'h2
  } sbst_dr_e;

endpackage : sbst_pkg

// ---- hdl/sbst_sync.sv ----
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module sbst_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_ff;

  // First stage feeds only the second
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule : sbst_sync

// ---- hdl/sbst_tap.sv ----
// Boundary-scan test access port of the synchronous SRAM
// Contract
// RULE1: Instruction 000 all-zero, 001 ident, 010 sample-hiz, 011 bypass, 100 sample, rest bypass.
// RULE2: All-zero instruction acts as sample but holds RAM outputs at high impedance.
// RULE3: Ident instruction loads fixed ID on capture and shifts it between TDI and TDO.
// RULE4: Ident is the active instruction after power-up and in test-logic-reset.
// RULE5: Bypass instructions put the one-bit bypass register in the scan path.
// RULE6: Sample captures ring inputs into the boundary register, then shifts it out.
// RULE7: Sample-hiz forces RAM outputs to high impedance and shifts the boundary register.
// RULE8: Codes 000 and 010 tri-state data drivers and capture pad values.
// RULE9: Controller keeps RAM inputs steady around the capture instant.
// RULE10: RAM clocks need stopping only while the ring is captured.
// RULE11: Undriven TDI or TMS reads as logic 1.
// RULE12: Narrow variant boundary register is 51 cells in fixed order.
// RULE13: Wide variant boundary register is 70 cells in its own order.
// RULE14: Boundary cell 1 sits nearest TDO and shifts out first.
// RULE15: Five test-clock rises with TMS high reach reset; power-up also resets.
// RULE16: ID register is 32 bits with bit 0 fixed at 1.
// RULE17: TMS and TDI sampled on test-clock rise; TDO updated on its fall.
// RULE18: Standard sixteen-state controller with capture, shift, update on both paths.
`timescale 1ns/1ps
module sbst_tap #(
  parameter bit          WIDE        = 1'b0,
  parameter logic [3:0]  ID_REVISION = 4'h0,    // Arbitrary value
  parameter logic [15:0] ID_PART     = 16'h5A5A, // Arbitrary value
  parameter logic [10:0] ID_VENDOR   = 11'h2A5,  // Arbitrary value
  localparam int         NCELL       = WIDE ? sbst_pkg::NCELL_X36 : sbst_pkg::NCELL_X18
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic             tms_driven,
  input  wire logic             tdi_driven,
  input  wire logic [NCELL-1:0] ring_in,
  output logic                  tdo,
  output logic                  tdo_oe,
  output logic                  ram_out_hiz
);

  localparam logic [sbst_pkg::ID_W-1:0] ID_VALUE =
    {ID_REVISION, ID_PART, ID_VENDOR, sbst_pkg::ID_FIX_BIT};

  logic [4:0]                    pin_s;
  logic [NCELL-1:0]              ring_s;
  logic                          tck_d_ff;
  logic                          tck_rise;
  logic                          tck_fall;
  logic                          tms_eff;
  logic                          tdi_eff;
  sbst_pkg::sbst_state_e         state_ff;
  sbst_pkg::sbst_state_e         nxt_state;
  logic [sbst_pkg::IR_W-1:0]     ir_sh_ff;
  logic [sbst_pkg::IR_W-1:0]     ir_ff;
  logic                          byp_ff;
  logic [sbst_pkg::ID_W-1:0]     id_ff;
  logic [NCELL-1:0]              bsr_ff;
  sbst_pkg::sbst_dr_e            dr_sel;
  logic                          ser_bit;
  logic                          shifting;

  // Test pins and ring pass two flops before use
  sbst_sync #(.W(5)) u_pin_sync (
    .clock (clock),
    .reset (reset),
    .din   ({tck, tms, tdi, tms_driven, tdi_driven}),
    .dout  (pin_s)
  );

  // Ring contents are steady at capture by the controller's duty
  sbst_sync #(.W(NCELL)) u_ring_sync ( // RULE9
    .clock (clock),
    .reset (reset),
    .din   (ring_in),
    .dout  (ring_s)
  );

  // Undriven inputs act as pulled high
  assign tms_eff = pin_s[1] ? pin_s[3] : 1'b1; // RULE11
  assign tdi_eff = pin_s[0] ? pin_s[2] : 1'b1; // RULE11

  // Test-clock edge detection
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tck_d_ff <= 1'b0;
    end else begin
      tck_d_ff <= pin_s[4];
    end
  end

  assign tck_rise = pin_s[4] & ~tck_d_ff; // RULE17
  assign tck_fall = ~pin_s[4] & tck_d_ff; // RULE17

  // Controller next state
  always_comb begin
    unique case (state_ff) // RULE18
      sbst_pkg::ST_RESET:    nxt_state = tms_eff ? sbst_pkg::ST_RESET   : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_IDLE:     nxt_state = tms_eff ? sbst_pkg::ST_SEL_DR  : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_DR:   nxt_state = tms_eff ? sbst_pkg::ST_SEL_IR  : sbst_pkg::ST_CAP_DR;
      sbst_pkg::ST_CAP_DR:   nxt_state = tms_eff ? sbst_pkg::ST_EX1_DR  : sbst_pkg::ST_SHIFT_DR;
      sbst_pkg::ST_SHIFT_DR: nxt_state = tms_eff ? sbst_pkg::ST_EX1_DR  : sbst_pkg::ST_SHIFT_DR;
      sbst_pkg::ST_EX1_DR:   nxt_state = tms_eff ? sbst_pkg::ST_UPD_DR  : sbst_pkg::ST_PAUSE_DR;
      sbst_pkg::ST_PAUSE_DR: nxt_state = tms_eff ? sbst_pkg::ST_EX2_DR  : sbst_pkg::ST_PAUSE_DR;
      sbst_pkg::ST_EX2_DR:   nxt_state = tms_eff ? sbst_pkg::ST_UPD_DR  : sbst_pkg::ST_SHIFT_DR;
      sbst_pkg::ST_UPD_DR:   nxt_state = tms_eff ? sbst_pkg::ST_SEL_DR  : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_IR:   nxt_state = tms_eff ? sbst_pkg::ST_RESET   : sbst_pkg::ST_CAP_IR;
      sbst_pkg::ST_CAP_IR:   nxt_state = tms_eff ? sbst_pkg::ST_EX1_IR  : sbst_pkg::ST_SHIFT_IR;
      sbst_pkg::ST_SHIFT_IR: nxt_state = tms_eff ? sbst_pkg::ST_EX1_IR  : sbst_pkg::ST_SHIFT_IR;
      sbst_pkg::ST_EX1_IR:   nxt_state = tms_eff ? sbst_pkg::ST_UPD_IR  : sbst_pkg::ST_PAUSE_IR;
      sbst_pkg::ST_PAUSE_IR: nxt_state = tms_eff ? sbst_pkg::ST_EX2_IR  : sbst_pkg::ST_PAUSE_IR;
      sbst_pkg::ST_EX2_IR:   nxt_state = tms_eff ? sbst_pkg::ST_UPD_IR  : sbst_pkg::ST_SHIFT_IR;
      sbst_pkg::ST_UPD_IR:   nxt_state = tms_eff ? sbst_pkg::ST_SEL_DR  : sbst_pkg::ST_IDLE;
    endcase
  end

  // Controller state, advanced on each test-clock rise
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_ff <= sbst_pkg::ST_RESET; // RULE15
    end else if (tck_rise) begin
      state_ff <= nxt_state; // RULE15
    end
  end

  // Instruction shift register and active instruction
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ir_sh_ff <= sbst_pkg::IR_CAPTURE;
      ir_ff    <= sbst_pkg::INS_IDENT; // RULE4
    end else if (state_ff == sbst_pkg::ST_RESET) begin
      ir_ff    <= sbst_pkg::INS_IDENT; // RULE4
    end else if (tck_rise) begin
      if (state_ff == sbst_pkg::ST_CAP_IR) begin
        ir_sh_ff <= sbst_pkg::IR_CAPTURE;
      end else if (state_ff == sbst_pkg::ST_SHIFT_IR) begin
        ir_sh_ff <= {tdi_eff, ir_sh_ff[sbst_pkg::IR_W-1:1]};
      end else if (state_ff == sbst_pkg::ST_UPD_IR) begin
        ir_ff    <= ir_sh_ff;
      end
    end
  end

  // Instruction decode to selected data register
  always_comb begin
    unique case (ir_ff) // RULE1
      sbst_pkg::INS_ZERO:   dr_sel = sbst_pkg::DR_BOUND; // RULE2
      sbst_pkg::INS_IDENT:  dr_sel = sbst_pkg::DR_IDENT;
      sbst_pkg::INS_SAMPZ:  dr_sel = sbst_pkg::DR_BOUND; // RULE7
      sbst_pkg::INS_SAMPLE: dr_sel = sbst_pkg::DR_BOUND; // RULE6
      default:              dr_sel = sbst_pkg::DR_BYPASS; // RULE5
    endcase
  end

  // RAM outputs forced off while a high-impedance instruction is loaded
  assign ram_out_hiz = (ir_ff == sbst_pkg::INS_ZERO) || (ir_ff == sbst_pkg::INS_SAMPZ); // RULE8

  // Bypass register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      byp_ff <= sbst_pkg::BYP_CAPTURE;
    end else if (tck_rise && dr_sel == sbst_pkg::DR_BYPASS) begin
      if (state_ff == sbst_pkg::ST_CAP_DR) begin
        byp_ff <= sbst_pkg::BYP_CAPTURE;
      end else if (state_ff == sbst_pkg::ST_SHIFT_DR) begin
        byp_ff <= tdi_eff; // RULE5
      end
    end
  end

  // Identification register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      id_ff <= ID_VALUE; // RULE16
    end else if (tck_rise && dr_sel == sbst_pkg::DR_IDENT) begin
      if (state_ff == sbst_pkg::ST_CAP_DR) begin
        id_ff <= ID_VALUE; // RULE3
      end else if (state_ff == sbst_pkg::ST_SHIFT_DR) begin
        id_ff <= {tdi_eff, id_ff[sbst_pkg::ID_W-1:1]}; // RULE3
      end
    end
  end

  // Boundary register, bit 0 is cell 1
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bsr_ff <= '0;
    end else if (tck_rise && dr_sel == sbst_pkg::DR_BOUND) begin
      if (state_ff == sbst_pkg::ST_CAP_DR) begin
        bsr_ff <= ring_s; // RULE6 RULE12 RULE13
      end else if (state_ff == sbst_pkg::ST_SHIFT_DR) begin
        bsr_ff <= {tdi_eff, bsr_ff[NCELL-1:1]}; // RULE14
      end
    end
  end

  // Serial output source
  always_comb begin
    if (state_ff == sbst_pkg::ST_SHIFT_IR) begin
      ser_bit = ir_sh_ff[0];
    end else begin
      unique case (dr_sel)
        sbst_pkg::DR_IDENT: ser_bit = id_ff[0];
        sbst_pkg::DR_BOUND: ser_bit = bsr_ff[0]; // RULE14
        default:            ser_bit = byp_ff;
      endcase
    end
  end

  assign shifting = (state_ff == sbst_pkg::ST_SHIFT_IR) || (state_ff == sbst_pkg::ST_SHIFT_DR);

  // Serial output and its enable change on test-clock fall
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= ser_bit; // RULE17
      tdo_oe <= shifting;
    end
  end

  // Helper: count of test-clock rises with mode select high
  logic [2:0] tms_hi_cnt_ff;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tms_hi_cnt_ff <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_eff) begin
        tms_hi_cnt_ff <= 3'h0;
      end else if (tms_hi_cnt_ff != 3'(sbst_pkg::TMS_RESET_EDGES)) begin
        tms_hi_cnt_ff <= tms_hi_cnt_ff + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_IR_RESET: assert property (state_ff == sbst_pkg::ST_RESET // RULE4
      |=> ir_ff == sbst_pkg::INS_IDENT)
    else $error("Instruction not ident after controller reset");
  AST_HIZ: assert property (tck_rise && state_ff == sbst_pkg::ST_UPD_IR // RULE8
      && (ir_sh_ff == sbst_pkg::INS_ZERO || ir_sh_ff == sbst_pkg::INS_SAMPZ)
      |=> ram_out_hiz)
    else $error("RAM outputs not forced off");
  AST_HIZ_OFF: assert property (tck_rise && state_ff == sbst_pkg::ST_UPD_IR // RULE2
      && ir_sh_ff == sbst_pkg::INS_SAMPLE |=> !ram_out_hiz)
    else $error("Sample instruction forced outputs off");
  AST_FIVE_TMS: assert property (tms_hi_cnt_ff == 3'(sbst_pkg::TMS_RESET_EDGES) // RULE15
      |-> state_ff == sbst_pkg::ST_RESET)
    else $error("Five high mode-select rises did not reach reset");
  AST_ID_CAP: assert property (tck_rise && state_ff == sbst_pkg::ST_CAP_DR // RULE3
      && ir_ff == sbst_pkg::INS_IDENT |=> id_ff == ID_VALUE && id_ff[0])
    else $error("ID capture wrong");
  AST_BSR_CAP: assert property (tck_rise && state_ff == sbst_pkg::ST_CAP_DR // RULE6
      && ir_ff == sbst_pkg::INS_SAMPLE |=> bsr_ff == $past(ring_s))
    else $error("Boundary capture wrong");
  AST_BSR_SHIFT: assert property (tck_rise && state_ff == sbst_pkg::ST_SHIFT_DR // RULE14
      && dr_sel == sbst_pkg::DR_BOUND |=> bsr_ff[0] == $past(bsr_ff[1]))
    else $error("Boundary shift order wrong");
  AST_UNDRIVEN: assert property (tck_rise && state_ff == sbst_pkg::ST_SHIFT_DR // RULE11
      && dr_sel == sbst_pkg::DR_BYPASS && !pin_s[0] |=> byp_ff)
    else $error("Undriven data input not read as one");
  AST_DECODE: assert property (ir_ff[2] && ir_ff[1:0] != 2'h0 // RULE1
      |-> dr_sel == sbst_pkg::DR_BYPASS)
    else $error("Upper codes not decoded as bypass");
  AST_TDO_FALL: assert property (tdo != $past(tdo) |-> $past(tck_fall)) // RULE17
    else $error("Serial output changed off a falling edge");

  CVR_ID_SHIFT: cover property (state_ff == sbst_pkg::ST_SHIFT_DR && ir_ff == sbst_pkg::INS_IDENT);
  CVR_SAMPLE: cover property (tck_rise && state_ff == sbst_pkg::ST_CAP_DR
      && ir_ff == sbst_pkg::INS_SAMPLE);
  CVR_HIZ: cover property (ram_out_hiz);
  CVR_BYPASS: cover property (state_ff == sbst_pkg::ST_SHIFT_DR && dr_sel == sbst_pkg::DR_BYPASS);

endmodule : sbst_tap

// ---- verification/sbst_ctl_model.sv ----
// Behavioural scan controller that drives the test port
`timescale 1ns/1ps
module sbst_ctl_model (
  input  wire logic clock,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      tms_driven,
  output logic      tdi_driven
);
  logic [1:0] released;  // Bit 0 mode line, bit 1 data line left floating

  // Test clock parked low, lines driven high
  initial begin
    tck        = 1'b0;
    tms        = 1'b1;
    tdi        = 1'b1;
    tms_driven = 1'b1;
    tdi_driven = 1'b1;
    released   = 2'h0;
  end

  // One 320 ns test-clock period; entered at a rising clock edge
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms        <= released[0] ? ~tms : m;  // Floating lines toggle, value meaningless
    tdi        <= released[1] ? ~tdi : d;
    tms_driven <= ~released[0];
    tdi_driven <= ~released[1];
    repeat (4) @(posedge clock);
    tck <= 1'b1;
    repeat (2) @(posedge clock);
    q  = tdo;  // Settled since the last fall, stable until the next
    oe = tdo_oe;
    repeat (2) @(posedge clock);
    tck <= 1'b0;
  endtask : step
endmodule : sbst_ctl_model

// ---- verification/sbst_tap_tb.sv ----
// Self-checking bench of the SRAM boundary-scan test access port
`timescale 1ns/1ps
module sbst_tap_tb;
  localparam int            NC   = sbst_pkg::NCELL_X18;
  localparam logic [3:0]    REV  = 4'h3;     // Arbitrary value
  localparam logic [15:0]   PART = 16'hC3A6; // Arbitrary value
  localparam logic [10:0]   VEND = 11'h15B;  // Arbitrary value
  localparam logic [31:0]   IDV  = {REV, PART, VEND, 1'b1};
  localparam logic [NC-1:0] DIN  = 51'h6_D3C1_96E5_0F7A;

  logic          clock;
  logic          reset;
  logic          tck, tms, tdi, tms_driven, tdi_driven;
  logic [NC-1:0] ring_in;
  logic          tdo, tdo_oe, ram_out_hiz;
  logic          q_d, oe_d;
  int            miscompares;
  int            samples_checked;

  // Design and far-side controller
  sbst_tap #(.WIDE(1'b0), .ID_REVISION(REV), .ID_PART(PART), .ID_VENDOR(VEND)) u_sbst_tap (
    .clock(clock), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
    .tms_driven(tms_driven), .tdi_driven(tdi_driven), .ring_in(ring_in),
    .tdo(tdo), .tdo_oe(tdo_oe), .ram_out_hiz(ram_out_hiz));
  sbst_ctl_model u_sbst_ctl_model (
    .clock(clock), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi),
    .tms_driven(tms_driven), .tdi_driven(tdi_driven));

  // 25 MHz clock
  always #20 clock = ~clock;

  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic go(input logic m);
    u_sbst_ctl_model.step(m, 1'b1, q_d, oe_d);
  endtask : go

  task automatic hiz_after(input logic exp);
    repeat (2) @(posedge clock);
    check(ram_out_hiz, exp);
  endtask : hiz_after

  // Idle to Idle through the instruction path
  task automatic load_ir(input logic [2:0] code);
    logic [2:0] cap;
    logic       q, oe;
    go(1'b1);
    go(1'b1);
    go(1'b0);
    go(1'b0);
    for (int i = 0; i < 3; i++) begin
      u_sbst_ctl_model.step(i == 2, code[i], q, oe);
      cap[i] = q;
      check(oe, 1'b1);
    end
    check(cap, 3'h1);
    go(1'b1);
    go(1'b0);
  endtask : load_ir

  // Idle to Idle through the data path; ring flips once capture is over
  task automatic dr_scan(output logic [NC-1:0] got);
    logic q, oe;
    go(1'b1);
    go(1'b0);
    go(1'b0);
    ring_in <= ~ring_in;
    for (int i = 0; i < NC; i++) begin
      u_sbst_ctl_model.step(i == NC - 1, DIN[i], q, oe);
      got[i] = q;
      check(oe, 1'b1);
    end
    go(1'b1);
    go(1'b0);
    check(tdo_oe, 1'b0);
  endtask : dr_scan

  function automatic logic [NC-1:0] expect_dr(input logic [2:0] c, input logic [NC-1:0] r);
    case (c)
      3'h0, 3'h2, 3'h4: return r;
      3'h1:             return {DIN[NC-33:0], IDV};
      default:          return {DIN[NC-2:0], 1'b0};
    endcase
  endfunction : expect_dr

  task automatic scn_power_up;
    logic [NC-1:0] got;
    check(ram_out_hiz, 1'b0);
    go(1'b0);
    dr_scan(got);
    check(got, expect_dr(3'h1, '0));
  endtask : scn_power_up

  task automatic scn_codes;
    logic [NC-1:0] got, exp;
    for (int c = 7; c >= 0; c--) begin
      ring_in <= DIN ^ {17{c[2:0]}};
      load_ir(c[2:0]);
      hiz_after(c == 0 || c == 2);
      exp = expect_dr(c[2:0], ring_in);
      dr_scan(got);
      check(got, exp);
    end
  endtask : scn_codes

  task automatic scn_tdi_float;
    logic [NC-1:0] got;
    u_sbst_ctl_model.released = 2'h2;
    load_ir(3'h0);  // Floating data line shifts in ones, so bypass loads
    hiz_after(1'b0);
    dr_scan(got);
    u_sbst_ctl_model.released = 2'h0;
    check(got, {{(NC-1){1'b1}}, 1'b0});
  endtask : scn_tdi_float

  task automatic scn_tms_float;
    logic [NC-1:0] got;
    load_ir(3'h2);
    go(1'b1);
    go(1'b0);
    go(1'b0);
    u_sbst_ctl_model.released = 2'h1;
    for (int i = 0; i < 5; i++) begin
      go(1'b0);
      hiz_after(i < 4);
    end
    u_sbst_ctl_model.released = 2'h0;
    go(1'b0);
    dr_scan(got);
    check(got, expect_dr(3'h1, '0));
  endtask : scn_tms_float

  task automatic scn_async_reset;
    logic [NC-1:0] got;
    load_ir(3'h0);
    hiz_after(1'b1);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    check(ram_out_hiz, 1'b0);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    go(1'b0);
    dr_scan(got);
    check(got, expect_dr(3'h1, '0));
  endtask : scn_async_reset

  // Guard against a hung run
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    results();
  end

  // Main sequence
  initial begin
    clock           = 1'b0;
    reset           = 1'b1;
    ring_in         = '0;
    miscompares     = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    scn_power_up();
    scn_codes();
    scn_tdi_float();
    scn_tms_float();
    scn_async_reset();
    results();
  end
endmodule : sbst_tap_tb
